// ===== rtl/power_up_and_bank_select.sv
`timescale 1ns/1ps
module power_up_and_bank_select
    import pwrup_pkg::*;
#(
    parameter int STAB_COUNT = STAB_CYCLES,
    parameter int RAMP_COUNT = RAMP_CYCLES,
    parameter bit SMALL_PART = 1'b0
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic serialClock,
    input wire logic chipSelect_n,
    input wire logic dataIn,
    input wire logic bank_pick_low,
    input wire logic bank_pick_high,
    input wire logic phraseStart,
    input wire logic [pwrup_pkg::ADDR_W-1:0] phraseAddr,
    input wire logic playActive,
    input wire logic playReady,
    output logic [pwrup_pkg::ADDR_W-1:0] memAddr,
    output logic oscEnable,
    output logic [pwrup_pkg::LEVEL_W-1:0] analog_output,
    output logic poweredUp,
    output logic [1:0] bankCount,
    output logic command_ready_out,
    output logic cmdValid,
    output logic [7:0] cmdByte
);
    import pwrup_pkg::*;

    logic byteToggle;
    logic [7:0] rxByte;
    logic tog1_q, tog2_q, tog3_q;
    logic [1:0] pick1_q, pick2_q, pickHeld_q;
    logic newByte;
    logic [3:0] opcode;
    power_e state_q;
    logic [31:0] timer_q;
    logic rampSoft_q;
    logic pdwnPending_q;
    logic [LEVEL_W-1:0] level_q;
    logic [31:0] rampStep;
    logic [ADDR_W-1:0] mapped;

    serial_byte_rx serial_byte_rx_i (
        .serialClock(serialClock),
        .reset_n(reset_n),
        .chipSelect_n(chipSelect_n),
        .dataIn(dataIn),
        .byteToggle(byteToggle),
        .byteData(rxByte)
    );

    // Toggle crossing; byte is stable long after the toggle flips
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tog1_q <= 1'b0;
            tog2_q <= 1'b0;
            tog3_q <= 1'b0;
        end else begin
            tog1_q <= byteToggle;
            tog2_q <= tog1_q;
            tog3_q <= tog2_q;
        end
    end
    assign newByte = tog2_q ^ tog3_q;
    assign opcode = rxByte[7:4];

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pick1_q <= 2'b00;
            pick2_q <= 2'b00;
        end else begin
            pick1_q <= {bank_pick_high, bank_pick_low};
            pick2_q <= pick1_q;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pickHeld_q <= 2'b00;
        end else if (phraseStart) begin
            pickHeld_q <= pick2_q;
        end
    end

    // Power state: reset is asynchronous so it cuts stabilising short
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_DOWN;
            timer_q <= '0;
            rampSoft_q <= 1'b0;
            pdwnPending_q <= 1'b0;
            bankCount <= BANKS_ONE;
        end else begin
            case (state_q)
                ST_DOWN: begin
                    // Anything but a power-up is dropped here
                    if (newByte && (opcode == OP_PUP_IMM
                            || opcode == OP_PUP_SOFT)) begin
                        state_q <= ST_STAB;
                        timer_q <= '0;
                        rampSoft_q <= (opcode == OP_PUP_SOFT);
                        bankCount <= rxByte[1:0];
                    end
                end
                ST_STAB: begin
                    // Bytes arriving here are not decoded at all
                    if (timer_q >= 32'(STAB_COUNT - 1)) begin
                        timer_q <= '0;
                        state_q <= rampSoft_q ? ST_RAMP_UP
                                              : ST_STANDBY;
                    end else begin
                        timer_q <= timer_q + 32'h1;
                    end
                end
                ST_RAMP_UP: begin
                    if (timer_q >= 32'(RAMP_COUNT - 1)) begin
                        timer_q <= '0;
                        state_q <= ST_STANDBY;
                    end else begin
                        timer_q <= timer_q + 32'h1;
                    end
                end
                ST_STANDBY: begin
                    if (newByte && (opcode == OP_PDWN_IMM
                            || opcode == OP_PDWN_SOFT)) begin
                        pdwnPending_q <= 1'b1;
                        rampSoft_q <= (opcode == OP_PDWN_SOFT);
                    end
                    if (pdwnPending_q && playReady && !playActive) begin
                        pdwnPending_q <= 1'b0;
                        timer_q <= '0;
                        state_q <= rampSoft_q ? ST_RAMP_DOWN : ST_DOWN;
                    end
                end
                ST_RAMP_DOWN: begin
                    if (timer_q >= 32'(RAMP_COUNT - 1)) begin
                        timer_q <= '0;
                        state_q <= ST_DOWN;
                    end else begin
                        timer_q <= timer_q + 32'h1;
                    end
                end
                default: state_q <= ST_DOWN;
            endcase
        end
    end

    // Output level: step for immediate, linear ramp for soft
    assign rampStep = (timer_q * 32'(IDLE_LEVEL)) / 32'(RAMP_COUNT);
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            level_q <= '0;
        end else begin
            case (state_q)
                ST_STANDBY: level_q <= IDLE_LEVEL;
                ST_RAMP_UP: level_q <= rampStep[LEVEL_W-1:0];
                ST_RAMP_DOWN: level_q <= IDLE_LEVEL - rampStep[LEVEL_W-1:0];
                default: level_q <= '0;
            endcase
        end
    end
    assign analog_output = level_q;

    // Bytes passed on to the playback side only in standby
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cmdValid <= 1'b0;
            cmdByte <= 8'h00;
        end else begin
            cmdValid <= newByte && state_q == ST_STANDBY;
            if (newByte) begin
                cmdByte <= rxByte;
            end
        end
    end

    bank_address_map bank_address_map_i (
        .bankCount(bankCount),
        .smallPart(SMALL_PART),
        .bankPick(pickHeld_q),
        .phraseAddr(phraseAddr),
        .memAddr(mapped)
    );

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            memAddr <= '0;
        end else begin
            memAddr <= mapped;
        end
    end

    assign oscEnable = (state_q != ST_DOWN);
    assign poweredUp = (state_q == ST_STANDBY);
    assign command_ready_out = (state_q == ST_DOWN)
        || (state_q == ST_STANDBY && playReady);
endmodule

// ===== rtl/pwrup_pkg.sv
package pwrup_pkg;
    localparam int CLOCK_MHZ = 250;
    localparam int STAB_TIME_US = 2000;
    localparam int RAMP_TIME_US = 64000;
    localparam int STAB_CYCLES = STAB_TIME_US * CLOCK_MHZ;
    localparam int RAMP_CYCLES = RAMP_TIME_US * CLOCK_MHZ;
    localparam int SIL_MIN_MS = 20;
    localparam int SIL_MAX_MS = 1024;
    localparam int SIL_STEP_MS = 4;
    localparam int PHRASES_PER_BANK = 256;
    localparam int MAX_BANKS = 4;
    localparam int ADDR_W = 20;
    localparam int LEVEL_W = 8;
    localparam logic [LEVEL_W-1:0] IDLE_LEVEL = 8'hFF;
    localparam logic [3:0] OP_PUP_IMM = 4'h0;
    localparam logic [3:0] OP_PUP_SOFT = 4'h1;
    localparam logic [3:0] OP_PDWN_IMM = 4'h2;
    localparam logic [3:0] OP_PDWN_SOFT = 4'h3;
    localparam logic [1:0] BANKS_ONE = 2'h0;
    localparam logic [1:0] BANKS_TWO = 2'h1;
    localparam logic [1:0] BANKS_FOUR = 2'h2;
    typedef enum logic [2:0] {
        ST_DOWN, ST_STAB, ST_RAMP_UP, ST_STANDBY, ST_RAMP_DOWN
    } power_e;
endpackage

// ===== rtl/serial_byte_rx.sv
`timescale 1ns/1ps
// Runs on the serial clock; select high clears the bit count.
module serial_byte_rx (
    input wire logic serialClock,
    input wire logic reset_n,
    input wire logic chipSelect_n,
    input wire logic dataIn,
    output logic byteToggle,
    output logic [7:0] byteData
);
    logic [2:0] bitCount_q;
    logic [6:0] shift_q;

    always_ff @(posedge serialClock or posedge chipSelect_n) begin
        if (chipSelect_n) begin
            bitCount_q <= 3'h0;
            shift_q <= 7'h00;
        end else begin
            bitCount_q <= bitCount_q + 3'h1;
            shift_q <= {shift_q[5:0], dataIn};
        end
    end

    // Byte and toggle persist across select so the fast side sees them;
    // reset clears the toggle too, else a stale toggle fakes a new byte
    always_ff @(posedge serialClock or negedge reset_n) begin
        if (!reset_n) begin
            byteData <= 8'h00;
            byteToggle <= 1'b0;
        end else if (!chipSelect_n && bitCount_q == 3'h7) begin
            byteData <= {shift_q, dataIn};
            byteToggle <= ~byteToggle;
        end
    end
endmodule

// ===== rtl/bank_address_map.sv
`timescale 1ns/1ps
module bank_address_map
    import pwrup_pkg::*;
#(
    parameter int AW = ADDR_W
) (
    input wire logic [1:0] bankCount,
    input wire logic smallPart,
    input wire logic [1:0] bankPick,
    input wire logic [AW-1:0] phraseAddr,
    output logic [AW-1:0] memAddr
);
    logic [AW-1:0] base;
    logic [AW-1:0] off;

    always_comb begin
        base = '0;
        off = phraseAddr;
        if (bankCount == BANKS_ONE) begin
            base = '0;
        end else if (smallPart || bankCount == BANKS_TWO) begin
            // Small part: count 10 gives two halves on the one pin
            base = {smallPart ? bankPick[0] : bankPick[0],
                {(AW-1){1'b0}}};
            off = {1'b0, phraseAddr[AW-2:0]};
        end else begin
            // 10 and the forbidden 11 both act as four banks
            base = {bankPick, {(AW-2){1'b0}}};
            off = {2'b00, phraseAddr[AW-3:0]};
        end
        memAddr = base | off;
    end
endmodule

// ===== test/power_up_and_bank_select_assertions.sv
`timescale 1ns/1ps
module power_up_and_bank_select_assertions
    import pwrup_pkg::*;
#(
    parameter int STAB_COUNT = 500,
    parameter int RAMP_COUNT = 100
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic playReady,
    input wire logic [pwrup_pkg::ADDR_W-1:0] phraseAddr,
    input wire logic [pwrup_pkg::ADDR_W-1:0] memAddr,
    input wire logic oscEnable,
    input wire logic [pwrup_pkg::LEVEL_W-1:0] analog_output,
    input wire logic poweredUp,
    input wire logic [1:0] bankCount,
    input wire logic command_ready_out,
    input wire logic cmdValid
);
    import pwrup_pkg::*;
    localparam int UP_LO = STAB_COUNT;
    localparam int UP_HI = STAB_COUNT + RAMP_COUNT + 4;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    down_ready_a: assert property (!oscEnable |->
        command_ready_out) else $error("not ready in power-down");
    down_quiet_a: assert property (!oscEnable ##1 !oscEnable |->
        analog_output == 8'h00)
        else $error("output not quiet in power-down");
    stab_hold_a: assert property ($rose(oscEnable) |->
        (oscEnable && !poweredUp) [*8]) else $error("standby too early");
    up_bound_a: assert property ($rose(oscEnable) |->
        ##[UP_LO:UP_HI] poweredUp) else $error("standby not reached");
    idle_level_a: assert property ($rose(poweredUp) |->
        ##[0:1] analog_output == IDLE_LEVEL) else $error("no idle level");
    fwd_standby_a: assert property (cmdValid |-> $past(poweredUp))
        else $error("byte forwarded outside standby");
    count_hold_a: assert property ($changed(bankCount) |->
        $rose(oscEnable)) else $error("bank count moved");
    one_bank_a: assert property (bankCount == 2'h0 ##1
        bankCount == 2'h0 |-> memAddr == $past(phraseAddr))
        else $error("one-bank address wrong");
    ready_idle_a: assert property (poweredUp |->
        command_ready_out == playReady) else $error("ready wrong");
    cover property ($rose(poweredUp));
    cover property (cmdValid);
    cover property (poweredUp && bankCount == 2'h3);
endmodule

// ===== test/serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model (
    output logic serialClock,
    output logic chipSelect_n,
    output logic dataIn
);
    initial begin
        serialClock = 1'b0;
        chipSelect_n = 1'b1;
        dataIn = 1'b0;
    end
    // Clock stands still between frames; nbits below 8 cuts a frame short
    task automatic send(input logic [7:0] value, input int nbits);
        chipSelect_n = 1'b0;
        for (int i = 7; i > 7 - nbits; i--) begin
            dataIn = value[i];
            #62.5 serialClock = 1'b1;
            #62.5 serialClock = 1'b0;
        end
        dataIn = ~dataIn;
        #62.5 chipSelect_n = 1'b1;
        #500;
    endtask
endmodule

// ===== test/power_up_and_bank_select_tb.sv
`timescale 1ns/1ps
module power_up_and_bank_select_tb;
    import pwrup_pkg::*;
    localparam int STAB = 500;
    localparam int RAMP = 100;
    logic clock, reset_n, serialClock, chipSelect_n, dataIn, loose;
    logic bank_pick_low, bank_pick_high, phraseStart, playActive, playReady;
    logic [19:0] phraseAddr, memAddr, expAddr, smallAddr;
    logic oscEnable, poweredUp, command_ready_out, cmdValid;
    logic [7:0] analog_output, cmdByte, b;
    logic [1:0] bankCount, cnt;
    logic [7:0] expQ[$];
    int fails = 0, checked = 0, cycles = 0, upCycles = 0, seed = 41754;

    power_up_and_bank_select #(.STAB_COUNT(STAB), .RAMP_COUNT(RAMP))
        power_up_and_bank_select_i (.clock, .reset_n, .serialClock,
        .chipSelect_n, .dataIn, .bank_pick_low, .bank_pick_high,
        .phraseStart, .phraseAddr, .playActive, .playReady, .memAddr,
        .oscEnable, .analog_output, .poweredUp, .bankCount,
        .command_ready_out, .cmdValid, .cmdByte);
    // Small part shares every input; only its address is compared
    power_up_and_bank_select #(.STAB_COUNT(STAB), .RAMP_COUNT(RAMP),
        .SMALL_PART(1'b1)) power_up_and_bank_select_small_i (.clock,
        .reset_n, .serialClock, .chipSelect_n, .dataIn, .bank_pick_low,
        .bank_pick_high, .phraseStart, .phraseAddr, .playActive,
        .playReady, .memAddr(smallAddr), .oscEnable(), .analog_output(),
        .poweredUp(), .bankCount(), .command_ready_out(), .cmdValid(),
        .cmdByte());
    serial_host_model serial_host_model_i (.serialClock, .chipSelect_n,
        .dataIn);

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("Counts: checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Bounded wait for idle level (up) or oscillator off (down)
    task automatic settle(input logic up);
        for (int n = 0; n < 3000; n++) begin
            @(negedge clock);
            if (up ? analog_output === IDLE_LEVEL : oscEnable === 1'b0) break;
        end
    endtask

    // Outputs are looked at mid-cycle, where they have settled
    always @(negedge clock) begin
        cycles++;
        if (oscEnable !== 1'b1) upCycles <= 0;
        else if (analog_output !== IDLE_LEVEL) upCycles <= upCycles + 1;
        if (cycles == 40000) begin
            fails++;
            complete_run;
        end
        if (cmdValid === 1'b1 && expQ.size() > 0) begin
            check(cmdByte, expQ.pop_front());
        end else if (cmdValid === 1'b1 && !loose) begin
            check(20'h1, 20'h0);
        end
    end

    initial begin
        reset_n = 1'b0;
        loose = 1'b0;
        phraseStart = 1'b0;
        playActive = 1'b0;
        playReady = 1'b1;
        {bank_pick_high, bank_pick_low} = 2'h0;
        phraseAddr = 20'h00000;
        repeat (8) @(negedge clock);
        reset_n = 1'b1;
        check(analog_output, 8'h00);
        check(command_ready_out, 1'b1);
        serial_host_model_i.send(8'h47, 8);
        check(oscEnable, 1'b0);
        serial_host_model_i.send(8'h02, 5);
        serial_host_model_i.send(8'h01, 8);
        check(bankCount, 2'h1);
        @(negedge clock) reset_n = 1'b0;
        #1 check(oscEnable, 1'b0);
        check(analog_output, 8'h00);
        @(negedge clock) reset_n = 1'b1;
        $display("Test reset done");
        for (int i = 0; i < 8; i++) begin
            cnt = i[1:0];
            b = {(i < 4) ? OP_PUP_IMM : OP_PUP_SOFT, 2'($random(seed)), cnt};
            serial_host_model_i.send(b, 8);
            serial_host_model_i.send(8'h66, 8);
            settle(1'b1);
            check(bankCount, cnt);
            check(upCycles >= STAB + (i < 4 ? 0 : RAMP - 2), 1'b1);
            check(upCycles <= STAB + 3 + (i < 4 ? 0 : RAMP), 1'b1);
            {bank_pick_high, bank_pick_low} = 2'($random(seed));
            phraseAddr = 20'($random(seed));
            repeat (4) @(negedge clock);
            phraseStart = 1'b1;
            @(negedge clock) phraseStart = 1'b0;
            case (cnt)
                2'h0: expAddr = phraseAddr;
                2'h1: expAddr = {bank_pick_low, phraseAddr[18:0]};
                default: expAddr = {bank_pick_high, bank_pick_low,
                    phraseAddr[17:0]};
            endcase
            {bank_pick_high, bank_pick_low} = ~{bank_pick_high, bank_pick_low};
            repeat (4) @(negedge clock);
            check(memAddr, expAddr);
            if (cnt == 2'h2) begin
                check(smallAddr, {expAddr[18], phraseAddr[18:0]});
            end
            b = 8'h60 | 8'($random(seed) & 15);
            expQ.push_back(b);
            serial_host_model_i.send(b, 8);
            loose = 1'b1;
            serial_host_model_i.send(i[0] ? 8'h30 : 8'h20, 8);
            settle(1'b0);
            // Output level is registered and trails the state by one cycle
            @(negedge clock);
            loose = 1'b0;
            check(analog_output, 8'h00);
            check(20'(expQ.size()), 20'h0);
            $display("Test %0d done", i);
        end
        complete_run;
    end
endmodule

bind power_up_and_bank_select power_up_and_bank_select_assertions #(
    .STAB_COUNT(STAB_COUNT), .RAMP_COUNT(RAMP_COUNT))
    power_up_and_bank_select_assertions_i (.clock, .reset_n, .playReady,
    .phraseAddr, .memAddr, .oscEnable, .analog_output, .poweredUp,
    .bankCount, .command_ready_out, .cmdValid);
